// file: src/ass_sequencer.sv
/*
 Analog input sequencer: triggers, pacing, scan, sample buffer, output codes, calibration store.
 Assumes the converter answers each conversion with a one-cycle done pulse and its result,
 and that the external trigger inputs are already synchronous to clk.
*/
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module ass_sequencer
    import ass_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int NCH   = 8,
    parameter int DW    = 16
)
(
    input  wire logic        clk,        // 25 MHz clock
    input  wire logic        rst,        // Async reset, high
    input  wire logic [5:0]  addr,       // Register byte address
    input  wire logic [31:0] wdata,      // Write data
    input  wire logic        wr,         // Write strobe
    input  wire logic        rd,         // Read strobe
    output logic      [31:0] rdata,      // Read data, cycle after rd
    input  wire logic        ext_start,  // External start trigger
    input  wire logic        ext_stop,   // External stop trigger
    input  wire logic        ext_clk,    // External sampling clock
    output logic             conv_go,    // Conversion start pulse
    output logic      [2:0]  conv_ch,    // Channel being converted
    input  wire logic        conv_done,  // Converter result valid
    input  wire logic [DW-1:0] conv_data, // Converter result
    output logic      [DW-1:0] ao0_code,  // Output channel 0 code
    output logic      [DW-1:0] ao1_code,  // Output channel 1 code
    output logic             ao_update,  // Output update pulse
    output logic             running,    // Acquisition active
    output logic             irq         // Level interrupt
);
    typedef enum logic [1:0] {
        ASS_IDLE = 2'b00,
        ASS_WAIT = 2'b01,
        ASS_CONV = 2'b10
    } ass_state_e;
    localparam int AW = $clog2(DEPTH);
    ass_state_e  state;
    logic [9:0]  ctrl;
    logic [31:0] pace;
    logic [31:0] count_lim;
    logic [31:0] sample_cnt;
    logic [31:0] pace_cnt;
    logic [8:0]  conv_cnt;
    logic [2:0]  last_ch;
    logic [ASS_NIRQ-1:0] irq_stat;
    logic [ASS_NIRQ-1:0] irq_mask;
    logic [DW-1:0] buf_mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   level;
    logic [3:0]    cal_adr;
    logic [15:0]   cal_mem [CAL_WORDS];
    logic [2:0]    raw_in;
    logic [2:0]    filt;
    logic [2:0]    filt_q;
    logic [2:0]    act_edge;
    logic          sw_start;
    logic          sw_stop;
    logic          tick;
    logic          start_ev;
    logic          stop_ev;
    logic          done_ev;
    logic          push;
    logic          pop;
    logic          ovf;
    logic          last_sample;
    logic [ASS_NIRQ-1:0] next_irq_stat;
    logic [ASS_NIRQ-1:0] next_irq_mask;

    ////////////////////////////////////////////////////////////////////////////
    // External inputs: glitch filter and edge select
    assign raw_in = {ext_clk, ext_stop, ext_start};
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_in
        logic [5:0] stab;
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                stab      <= 6'h00;
                filt[gi]  <= 1'b0;
            end
            else if (!ctrl[ASS_CTL_FILT+gi] || raw_in[gi] == filt[gi] || stab == 6'(FILT_CYC - 1))
            begin
                stab      <= 6'h00;
                filt[gi]  <= raw_in[gi];
            end
            else
                stab <= stab + 6'h01;
        end
        assign act_edge[gi] = ctrl[ASS_CTL_EDGE+gi] ? (filt_q[gi] & ~filt[gi])
                                                    : (~filt_q[gi] & filt[gi]);
    end

    // Previous filtered level for edge detect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            filt_q <= 3'h0;
        else
            filt_q <= filt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger and stop decisions
    // start source select
    assign start_ev = ctrl[ASS_CTL_EXTSTA] ? act_edge[0] : sw_start;
    assign last_sample = ctrl[ASS_CTL_STOPSEL+:2] == ASS_STOP_COUNT && sample_cnt + 32'h1 == count_lim;
    assign stop_ev = (ctrl[ASS_CTL_STOPSEL+:2] == ASS_STOP_EXT && act_edge[1])
                   || (ctrl[ASS_CTL_STOPSEL+:2] == ASS_STOP_SW && sw_stop)
                   || (push && last_ch == 3'(NCH - 1) && last_sample);
    assign tick = ctrl[ASS_CTL_EXTCLK] ? act_edge[2] : (pace_cnt == 32'h0);
    assign sw_start = wr && addr == ASS_REG_CMD && wdata[0];
    assign sw_stop  = wr && addr == ASS_REG_CMD && wdata[1];

    // Internal timebase, reloads each period
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pace_cnt <= 32'h0;
        else if (state == ASS_IDLE || pace_cnt == 32'h0)
            pace_cnt <= pace;
        else
            pace_cnt <= pace_cnt - 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan state machine
    // autonomous scan
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state      <= ASS_IDLE;
            conv_go    <= 1'b0;
            conv_ch    <= 3'h0;
            last_ch    <= 3'h0;
            conv_cnt   <= 9'h0;
            sample_cnt <= 32'h0;
            running    <= 1'b0;
        end
        else
        begin
            conv_go <= 1'b0;
            unique case (state)
                ASS_IDLE:
                begin
                    if (start_ev)
                    begin
                        state      <= ASS_WAIT;
                        running    <= 1'b1;
                        sample_cnt <= 32'h0;
                    end
                end
                ASS_WAIT:
                begin
                    if (stop_ev)
                    begin
                        state   <= ASS_IDLE;
                        running <= 1'b0;
                    end
                    else if (tick)
                    begin
                        state    <= ASS_CONV;
                        conv_go  <= 1'b1;
                        conv_ch  <= 3'h0;
                        last_ch  <= 3'h0;
                        conv_cnt <= 9'h0;
                    end
                end
                ASS_CONV:
                begin
                    if (conv_cnt != 9'(CONV_CYC))
                        conv_cnt <= conv_cnt + 9'h1;
                    if (stop_ev)
                    begin
                        state      <= ASS_IDLE;
                        running    <= 1'b0;
                        sample_cnt <= sample_cnt + 32'(last_sample); // Final scan of a count stop counts too
                    end
                    else if (conv_done && conv_cnt >= 9'(CONV_CYC - 1))
                    begin
                        if (last_ch == 3'(NCH - 1))
                        begin
                            state      <= ASS_WAIT;
                            sample_cnt <= sample_cnt + 32'h1;
                        end
                        else
                        begin
                            conv_go  <= 1'b1;
                            conv_ch  <= last_ch + 3'h1;
                            last_ch  <= last_ch + 3'h1;
                            conv_cnt <= 9'h0;
                        end
                    end
                end
                default:
                    state <= ASS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample buffer
    // sixteen-bit result per channel
    assign push = state == ASS_CONV && conv_done && conv_cnt >= 9'(CONV_CYC - 1);
    assign pop  = rd && addr == ASS_REG_FIFO && level != '0;
    assign ovf  = push && level == (AW+1)'(DEPTH);
    assign done_ev = running && stop_ev;

    always_ff @(posedge clk)
    begin
        if (push && !ovf)
            buf_mem[wptr] <= conv_data;
    end

    // Pointers and fill level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end
        else
        begin
            if (push && !ovf)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1;
            level <= level + (AW+1)'(push && !ovf) - (AW+1)'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    // user calibration words above factory set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl      <= 10'h000;
            pace      <= ASS_PACE_RST;
            count_lim <= 32'h0000_0001;
            irq_mask  <= '0;
            cal_adr   <= 4'h0;
            ao0_code  <= '0;
            ao1_code  <= '0;
            ao_update <= 1'b0;
        end
        else
        begin
            ao_update <= 1'b0;
            if (wr)
            begin
                unique case (addr)
                    ASS_REG_CTRL:   ctrl      <= wdata[9:0];
                    ASS_REG_PACE:   pace      <= wdata;
                    ASS_REG_COUNT:  count_lim <= wdata;
                    ASS_REG_MASK:   irq_mask  <= wdata[ASS_NIRQ-1:0];
                    ASS_REG_CALADR: cal_adr   <= wdata[3:0];
                    ASS_REG_AO0:
                    begin
                        ao0_code  <= wdata[DW-1:0];
                        ao_update <= 1'b1;
                    end
                    ASS_REG_AO1:
                    begin
                        ao1_code  <= wdata[DW-1:0];
                        ao_update <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Calibration store; factory words are not writable
    always_ff @(posedge clk)
    begin
        if (wr && addr == ASS_REG_CALDAT && cal_adr >= 4'(CAL_FACTORY))
            cal_mem[cal_adr] <= wdata[15:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over write-one-clear
    assign next_irq_stat = (irq_stat & ~((wr && addr == ASS_REG_IRQ) ? wdata[ASS_NIRQ-1:0] : '0))
                         | {push, state == ASS_IDLE && start_ev, ovf, done_ev};
    // Mask as it stands after this edge, so irq never lags a mask write
    assign next_irq_mask = (wr && addr == ASS_REG_MASK) ? wdata[ASS_NIRQ-1:0] : irq_mask;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & next_irq_mask);
        end
    end

    // Read port, data valid the cycle after rd
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 32'h0;
        else if (rd)
        begin
            unique case (addr)
                ASS_REG_CTRL:   rdata <= {22'h0, ctrl};
                ASS_REG_STATUS: rdata <= {19'h0, 11'(level), state == ASS_CONV, running};
                ASS_REG_IRQ:    rdata <= {28'h0, irq_stat};
                ASS_REG_MASK:   rdata <= {28'h0, irq_mask};
                ASS_REG_PACE:   rdata <= pace;
                ASS_REG_COUNT:  rdata <= count_lim;
                ASS_REG_FIFO:   rdata <= {16'h0, buf_mem[rptr]};
                ASS_REG_AO0:    rdata <= {16'h0, ao0_code};
                ASS_REG_AO1:    rdata <= {16'h0, ao1_code};
                ASS_REG_CALADR: rdata <= {28'h0, cal_adr};
                ASS_REG_CALDAT: rdata <= {16'h0, cal_mem[cal_adr]};
                ASS_REG_SCAN:   rdata <= sample_cnt;
                default:        rdata <= 32'h0;
            endcase
        end
        else
            rdata <= 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_ovf_flag: assert property (@(posedge clk) disable iff (rst) ovf |=> irq_stat[ASS_IRQ_OVF])
        else $error("overflow not flagged");
    chk_irq_level: assert property (@(posedge clk) disable iff (rst) (|(irq_stat & irq_mask)) |-> irq)
        else $error("irq low with pending bit");
    chk_conv_time: assert property (@(posedge clk) disable iff (rst) push |-> conv_cnt >= 9'(CONV_CYC - 1))
        else $error("conversion too short");
    chk_start_run: assert property (@(posedge clk) disable iff (rst)
        (state == ASS_IDLE && start_ev) |=> running && state == ASS_WAIT)
        else $error("start not taken");
    chk_stop_idle: assert property (@(posedge clk) disable iff (rst)
        (state != ASS_IDLE && stop_ev) |=> !running ##1 !running)
        else $error("stop not taken");
    chk_count_stop: assert property (@(posedge clk) disable iff (rst)
        (push && last_ch == 3'(NCH - 1) && last_sample) |=> state == ASS_IDLE)
        else $error("count stop missed");
    chk_buf_bound: assert property (@(posedge clk) disable iff (rst) level <= (AW+1)'(DEPTH))
        else $error("buffer level beyond depth");
    chk_go_tick: assert property (@(posedge clk) disable iff (rst)
        (state == ASS_WAIT && tick && !stop_ev) |=> conv_go && conv_ch == 3'h0)
        else $error("tick did not start scan");
endmodule : ass_sequencer

// file: src/ass_pkg.sv
/*
 Constants, register offsets and timing figures for the analog sampling sequencer.
 Assumes a single 25 MHz clock and a plain register port driven by a synchronous master.
*/
package ass_pkg;
    // Register offsets
    localparam logic [5:0] ASS_REG_CTRL    = 6'h00;
    localparam logic [5:0] ASS_REG_CMD     = 6'h04;
    localparam logic [5:0] ASS_REG_STATUS  = 6'h08;
    localparam logic [5:0] ASS_REG_IRQ     = 6'h0c;
    localparam logic [5:0] ASS_REG_MASK    = 6'h10;
    localparam logic [5:0] ASS_REG_PACE    = 6'h14;
    localparam logic [5:0] ASS_REG_COUNT   = 6'h18;
    localparam logic [5:0] ASS_REG_FIFO    = 6'h1c;
    localparam logic [5:0] ASS_REG_AO0     = 6'h20;
    localparam logic [5:0] ASS_REG_AO1     = 6'h24;
    localparam logic [5:0] ASS_REG_CALADR  = 6'h28;
    localparam logic [5:0] ASS_REG_CALDAT  = 6'h2c;
    localparam logic [5:0] ASS_REG_SCAN    = 6'h30;
    // Control field positions
    localparam int ASS_CTL_EXTCLK  = 0;
    localparam int ASS_CTL_EXTSTA  = 1;
    localparam int ASS_CTL_STOPSEL = 2; // two bits
    localparam int ASS_CTL_EDGE    = 4; // three bits: start, stop, clock; 1 = falling
    localparam int ASS_CTL_FILT    = 7; // three bits
    // Stop source codes
    localparam logic [1:0] ASS_STOP_COUNT = 2'h0;
    localparam logic [1:0] ASS_STOP_EXT   = 2'h1;
    localparam logic [1:0] ASS_STOP_SW    = 2'h2;
    // Interrupt bit positions
    localparam int ASS_IRQ_DONE  = 0;
    localparam int ASS_IRQ_OVF   = 1;
    localparam int ASS_IRQ_START = 2;
    localparam int ASS_IRQ_SAMP  = 3;
    localparam int ASS_NIRQ      = 4;
    // Timing
    localparam int CLK_MHZ         = 25;
    localparam int FILT_NS         = 1000;
    localparam int FILT_CYC        = (FILT_NS * CLK_MHZ) / 1000;
    localparam int CONV_US         = 10;
    localparam int CONV_CYC        = CONV_US * CLK_MHZ;
    localparam logic [31:0] ASS_PACE_RST = 32'h0000_09c4;
    localparam int CAL_WORDS       = 16;
    localparam int CAL_FACTORY     = 8;
endpackage : ass_pkg

// file: testbench/ass_conv_model.sv
/*
 Behavioural converter standing at the far side of the sampling sequencer.
 Assumes conv_go is a one-cycle pulse and that no new request comes while a conversion runs.
*/
`timescale 1ns/1ps
module ass_conv_model
    import ass_pkg::*;
#(
    parameter int DLY = 250
)
(
    input  wire logic        clk,       // Board clock
    input  wire logic        rst,       // Async reset, high
    input  wire logic        conv_go,   // Conversion request
    input  wire logic [2:0]  conv_ch,   // Channel to convert
    output logic             conv_done, // Result pulse
    output logic      [15:0] conv_data  // Result word
);
    logic [15:0] sent[$];  // Results handed over, oldest first
    int          n_go;     // Requests seen
    int          cnt;      // Cycles since request
    logic        busy;     // Conversion in flight
    logic [2:0]  ch;       // Latched channel
    logic [11:0] seq;      // Running result number
    ////////////////////////////////////////////////////////////////////////////////
    // Convert with a channel-tagged result so scan order shows in the data
    // tagged result, slow answer
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            conv_done <= 1'b0;
            conv_data <= 16'h0000;
            n_go      <= 0;
            cnt       <= 0;
            busy      <= 1'b0;
            ch        <= 3'h0;
            seq       <= 12'h000;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data; // Toggles between results so stale data never looks valid
            if (conv_go)
            begin
                busy <= 1'b1;
                cnt  <= 1;
                ch   <= conv_ch;
                n_go <= n_go + 1;
            end
            else if (busy)
            begin
                cnt <= cnt + 1;
                if (cnt == DLY - 1)
                begin
                    busy      <= 1'b0;
                    conv_done <= 1'b1;
                    conv_data <= {ch, 1'b0, seq};
                    seq       <= seq + 12'h001;
                    sent.push_back({ch, 1'b0, seq});
                end
            end
        end
    end
endmodule : ass_conv_model

// file: testbench/tb_analog_sampling_sequencer.sv
/*
 Self-checking bench for the sampling sequencer: register port, triggers, pacing, buffer, interrupt.
 Assumes the converter model above and a small buffer depth so overflow comes quickly.
*/
`timescale 1ns/1ps
module tb_analog_sampling_sequencer
    import ass_pkg::*;
();
    logic        clk, rst, wr, rd, ext_start, ext_stop, ext_clk;
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, v, w;
    logic        conv_go, conv_done, ao_update, running, irq, a;
    logic [2:0]  conv_ch;
    logic [15:0] conv_data, ao0_code, ao1_code;
    int          fail_count, n_checks, g, seed;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and converter
    ass_sequencer #(.DEPTH(16)) u_ass_sequencer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_start(ext_start), .ext_stop(ext_stop), .ext_clk(ext_clk),
        .conv_go(conv_go), .conv_ch(conv_ch), .conv_done(conv_done), .conv_data(conv_data),
        .ao0_code(ao0_code), .ao1_code(ao1_code), .ao_update(ao_update), .running(running), .irq(irq));
    ass_conv_model u_ass_conv_model (.clk(clk), .rst(rst), .conv_go(conv_go), .conv_ch(conv_ch),
        .conv_done(conv_done), .conv_data(conv_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Strobes drop one edge before the next access may raise them again
    task automatic wreg(input logic [5:0] ad, input logic [31:0] d);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg
    task automatic rreg(input logic [5:0] ad, output logic [31:0] d);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rreg
    task automatic drain(input int n);
        logic [31:0] x;
        repeat (n)
        begin
            rreg(ASS_REG_FIFO, x);
            chk(32'(x[15:0]), 32'(u_ass_conv_model.sent.pop_front()));
        end
        u_ass_conv_model.sent.delete();
    endtask : drain
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (running !== 1'b0 && k < lim)
        begin
            @(posedge clk);
            k++;
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the expected run of about 27000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        close_out();
    end
    // Main sequence
    initial
    begin
        {rst, wr, rd, ext_stop, ext_clk, addr, wdata} = '0;
        rst = 1'b1;
        ext_start = 1'b1;
        fail_count = 0;
        n_checks = 0;
        seed = 32'h8b2d;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rreg(ASS_REG_CTRL, v);
        chk(v, 32'h0);
        rreg(ASS_REG_PACE, v);
        chk(v, ASS_PACE_RST);
        rreg(ASS_REG_COUNT, v);
        chk(v, 32'h1);
        rreg(6'h3c, v);
        chk(v, 32'h0);
        $display("test reset done");
        // Output codes and user calibration store with random values
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wreg(i[0] ? ASS_REG_AO1 : ASS_REG_AO0, v);
            chk(32'(ao_update), 32'h1);
            chk(32'(i[0] ? ao1_code : ao0_code), 32'(v[15:0]));
            wreg(ASS_REG_CALADR, 32'(CAL_FACTORY + i));
            wreg(ASS_REG_CALDAT, v);
            rreg(ASS_REG_CALDAT, w);
            chk(32'(w[15:0]), 32'(v[15:0]));
        end
        // Factory words must not take a software write
        wreg(ASS_REG_CALADR, 32'h0);
        wreg(ASS_REG_CALDAT, v);
        rreg(ASS_REG_CALDAT, w);
        chk(32'(w[15:0] !== v[15:0]), 32'h1);
        $display("test outputs done");
        // One scan under software start, count stop, then interrupt raise, mask and clear
        wreg(ASS_REG_CMD, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(running), 32'h1);
        wait_idle(6000);
        chk(32'(running), 32'h0);
        rreg(ASS_REG_SCAN, v);
        chk(v, 32'h1);
        rreg(ASS_REG_STATUS, v);
        chk(32'(v[12:2]), 32'h8);
        drain(8);
        rreg(ASS_REG_IRQ, v);
        chk(32'(v[ASS_IRQ_DONE]), 32'h1);
        wreg(ASS_REG_MASK, 32'h0);
        a = irq;
        wreg(ASS_REG_MASK, 32'hf);
        chk(32'(a ^ irq), 32'h1);
        wreg(ASS_REG_IRQ, 32'hf);
        chk(32'(irq), 32'h0);
        wreg(ASS_REG_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test count stop done");
        // Filtered falling start edge: a short glitch is ignored, a long low starts
        wreg(ASS_REG_CTRL, (32'h1 << ASS_CTL_EXTSTA) | (32'h1 << ASS_CTL_EDGE) | (32'h1 << ASS_CTL_FILT));
        ext_start <= 1'b0;
        repeat (10) @(posedge clk);
        ext_start <= 1'b1;
        repeat (100) @(posedge clk);
        chk(32'(running), 32'h0);
        ext_start <= 1'b0;
        repeat (40) @(posedge clk);
        chk(32'(running), 32'h1);
        ext_start <= 1'b1;
        wait_idle(6000);
        drain(8);
        $display("test external start done");
        // External pacing clock and external stop
        wreg(ASS_REG_CTRL, (32'h1 << ASS_CTL_EXTCLK) | (32'(ASS_STOP_EXT) << ASS_CTL_STOPSEL));
        wreg(ASS_REG_CMD, 32'h1);
        g = u_ass_conv_model.n_go;
        repeat (3000) @(posedge clk);
        chk(32'(u_ass_conv_model.n_go - g), 32'h0);
        ext_clk <= 1'b1;
        repeat (5) @(posedge clk);
        ext_clk <= 1'b0;
        repeat (2200) @(posedge clk);
        chk(32'(u_ass_conv_model.n_go - g), 32'h8);
        ext_stop <= 1'b1;
        repeat (5) @(posedge clk);
        ext_stop <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(running), 32'h0);
        drain(8);
        $display("test external clock done");
        // Software stop in mid-scan
        wreg(ASS_REG_CTRL, 32'(ASS_STOP_SW) << ASS_CTL_STOPSEL);
        wreg(ASS_REG_COUNT, 32'd100);
        wreg(ASS_REG_CMD, 32'h1);
        repeat (2800) @(posedge clk);
        chk(32'(running), 32'h1);
        wreg(ASS_REG_CMD, 32'h2);
        repeat (3) @(posedge clk);
        chk(32'(running), 32'h0);
        // Let the converter finish the cut conversion so its stray result is discarded
        repeat (300) @(posedge clk);
        rreg(ASS_REG_STATUS, v);
        chk(32'(v[12:2]), 32'h1);
        drain(int'(v[12:2]));
        $display("test software stop done");
        // Three scans into a 16-word buffer: fills, refuses, flags overflow, drains
        wreg(ASS_REG_CTRL, 32'h0);
        wreg(ASS_REG_COUNT, 32'h3);
        wreg(ASS_REG_IRQ, 32'hf);
        wreg(ASS_REG_CMD, 32'h1);
        wait_idle(10000);
        rreg(ASS_REG_SCAN, v);
        chk(v, 32'h3);
        rreg(ASS_REG_STATUS, v);
        chk(32'(v[12:2]), 32'd16);
        rreg(ASS_REG_IRQ, v);
        chk(32'(v[ASS_IRQ_OVF]), 32'h1);
        drain(16);
        rreg(ASS_REG_STATUS, v);
        chk(32'(v[12:2]), 32'h0);
        $display("test overflow done");
        close_out();
    end
endmodule : tb_analog_sampling_sequencer
